// ===== core/hpms_params.svh
// Constants for the host-port pin selection block.
`ifndef HPMS_PARAMS_SVH
`define HPMS_PARAMS_SVH
`define HPMS_DATA_W 32
`define HPMS_RX_HI 31
`define HPMS_RX_LO 24
`define HPMS_TX_HI 22
`define HPMS_TX_LO 16
`define HPMS_RX_W 8
`define HPMS_TX_W 7
`define HPMS_STRAP_OFF 1'h0
`define HPMS_STRAP_ON 1'h1
`define HPMS_ZERO32 32'h0000_0000
`define HPMS_MII_MASK 32'hff7f_0000
`define HPMS_FILL_LAST 2'h2
`define HPMS_FILL_STEP 2'h1
`endif

// ===== core/hpms_pkg.sv
// Types shared by the host-port pin selection block.
package hpms_pkg;
	// Pin function chosen for the shared data pins.
	typedef enum logic [1:0] {
		HPMS_FN_HOST = 2'b00,
		HPMS_FN_PCI = 2'b01
	} hpms_fn_type;
	// Latched selection.
	typedef struct packed {
		logic pci_en;
		logic ethernet_mac_unit_en;
		logic mdio_en;
	} hpms_sel_type;
endpackage : hpms_pkg

// ===== core/hpms_pin_select.sv
// Reset-time strap capture and host-port data pin multiplexer.
// Notes on behaviour
// RULE_01: With neither strap set at reset the data pins serve the host port and PCI is off.
// RULE_02: A PCI strap of 1 at reset enables PCI and gives it the data pins instead of the host port.
// RULE_03: An MAC strap of 1 at reset enables the Ethernet MAC, and 0 leaves it off.
// RULE_04: With the MAC on, pins 31..24 carry MII receive and pins 22..16 MII transmit, never pin 23 or 15..0.
// RULE_05: A controller on address lines 18..0 drives reset levels during reset or leaves them undriven.
// RULE_06: The MAC strap enables the management data interface together with the MAC.
// RULE_07: Straps are captured once at reset release and held until the next reset.
`include "hpms_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hpms_pin_select #(
	parameter int DATA_W = `HPMS_DATA_W // Width of the shared data pins.
) (
	input wire logic clk, // System clock, 100 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic pci_select_strap, // PCI strap pin level.
	input wire logic ethernet_mac_unit_select_strap, // MAC strap pin level.
	input wire logic [31:0] host_port_data_pins_in, // Pad input levels.
	output logic [31:0] host_port_data_pins_out, // Pad output levels.
	output logic [31:0] host_port_data_pins_oe, // Pad enables, high drives.
	input wire logic [31:0] host_port_out, // Host port drive data.
	input wire logic [31:0] host_port_oe, // Host port drive enables.
	input wire logic [31:0] pci_ad_out, // PCI drive data.
	input wire logic [31:0] pci_ad_oe, // PCI drive enables.
	input wire logic [6:0] mii_tx_out, // MII transmit side data.
	input wire logic [6:0] mii_tx_oe, // MII transmit side enables.
	output logic [7:0] mii_rx_in, // MII receive side levels.
	output logic [6:0] mii_tx_in, // MII transmit side pad levels.
	output logic [31:0] data_pins_in, // Pad levels to host or PCI.
	output var hpms_pkg::hpms_sel_type sel, // Latched selection.
	output logic sel_valid // Selection has been captured.
);
	//////////////////////////////////////////////////////////////////////
	// Elaboration check on the pin width.
	// The MII lanes sit at fixed pin positions inside a 32-bit bus, so the
	// routing map below cannot be stretched or shrunk by a parameter.
	// A narrower bus would lose the receive lanes at the top and a wider
	// one would leave pins that neither the host port nor PCI can own.
	// Any other width is therefore refused here rather than mis-routed.
	generate
		if (DATA_W != `HPMS_DATA_W) begin : g_bad_width
			$error("hpms_pin_select supports only a 32-bit data pin bus");
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// Strap synchronisers; first stage is read only by the second.
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
		end else begin
			strap_s1 <= {ethernet_mac_unit_select_strap, pci_select_strap};
			strap_s2 <= strap_s1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Capture after the synchroniser has filled, so the pads have settled.
	logic [1:0] fill;
	logic captured;
	hpms_pkg::hpms_sel_type next_sel;
	// The fill counter waits out the two synchroniser stages, so the value
	// taken is the strap level seen after reset release, never a reset zero.
	// Capture happens exactly once; later strap movement is ignored, which
	// keeps a loose strap resistor from re-routing pins in mid-operation.
	wire capture_now = (fill == `HPMS_FILL_LAST) && !captured;
	assign next_sel.pci_en = strap_s2[0]; // RULE_02
	assign next_sel.ethernet_mac_unit_en = strap_s2[1]; // RULE_03
	assign next_sel.mdio_en = strap_s2[1]; // RULE_06
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fill <= 2'h0;
			captured <= 1'b0;
			sel <= '0;
		end else begin
			if (fill != `HPMS_FILL_LAST) fill <= fill + `HPMS_FILL_STEP;
			if (capture_now) begin
				captured <= 1'b1;
				sel <= next_sel; // RULE_07
			end
		end
	end
	assign sel_valid = captured;

	//////////////////////////////////////////////////////////////////////
	// Pin routing; pads stay undriven until the selection is known.
	hpms_pkg::hpms_fn_type fn;
	assign fn = sel.pci_en ? hpms_pkg::HPMS_FN_PCI : hpms_pkg::HPMS_FN_HOST;
	logic [31:0] base_out;
	logic [31:0] base_oe;
	wire use_pci = (fn == hpms_pkg::HPMS_FN_PCI); // RULE_02
	assign base_out = use_pci ? pci_ad_out : host_port_out; // RULE_01
	assign base_oe = use_pci ? pci_ad_oe : host_port_oe; // RULE_01
	logic [31:0] mii_mask;
	// With the MAC on it takes pins 31..24 and 22..16 from both the host port
	// and PCI; pin 23 and pins 15..0 keep the base function in every case.
	assign mii_mask = sel.ethernet_mac_unit_en ? `HPMS_MII_MASK : `HPMS_ZERO32; // RULE_04
	logic [31:0] mii_out;
	logic [31:0] mii_oe;
	assign mii_out = {8'h00, 1'b0, mii_tx_out, 16'h0000};
	assign mii_oe = {8'h00, 1'b0, mii_tx_oe, 16'h0000}; // RULE_04
	logic [31:0] next_out;
	logic [31:0] next_oe;
	// Enables stay low until capture, so no pad fights a strap resistor or
	// an external driver while the selection is still unknown.
	assign next_out = (base_out & ~mii_mask) | (mii_out & mii_mask);
	assign next_oe = captured ?
		((base_oe & ~mii_mask) | (mii_oe & mii_mask)) : `HPMS_ZERO32;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_port_data_pins_out <= `HPMS_ZERO32;
			host_port_data_pins_oe <= `HPMS_ZERO32;
		end else begin
			host_port_data_pins_out <= next_out;
			host_port_data_pins_oe <= next_oe;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Incoming pad levels; receive side is only live with the MAC on.
	// These paths are plain masks with no flops: the MII receive lanes carry
	// their own clock, so the MAC resynchronises them itself, and a stage
	// here would only add skew between the receive clock and its data.
	// The host port and PCI see MII pins as zero, so a MAC frame on the pads
	// cannot be mistaken for host or PCI traffic.
	assign data_pins_in = host_port_data_pins_in & ~mii_mask;
	assign mii_rx_in = sel.ethernet_mac_unit_en ?
		host_port_data_pins_in[`HPMS_RX_HI:`HPMS_RX_LO] : 8'h00; // RULE_04
	assign mii_tx_in = sel.ethernet_mac_unit_en ?
		host_port_data_pins_in[`HPMS_TX_HI:`HPMS_TX_LO] : 7'h00;

	//////////////////////////////////////////////////////////////////////
	// Checks.
	AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		captured && $past(captured) |-> $stable(sel))
		else $error("selection changed after capture");
	AST_MDIO_PAIR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		sel.mdio_en == sel.ethernet_mac_unit_en) else $error("mdio not paired");
	AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		capture_now |=> captured && sel.pci_en == $past(strap_s2[0]))
		else $error("pci strap not captured");
	AST_NO_MII_LOW: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		captured |=> host_port_data_pins_oe[15:0] == $past(base_oe[15:0]))
		else $error("low pins disturbed");
	AST_MII_TX: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		captured && sel.ethernet_mac_unit_en |=>
		host_port_data_pins_oe[22:16] == $past(mii_tx_oe))
		else $error("mii transmit enables wrong");
	AST_RX_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		captured && sel.ethernet_mac_unit_en |=> host_port_data_pins_oe[31:24] == 8'h00)
		else $error("receive pins driven");
	AST_HOST: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		captured && !sel.pci_en |=>
		host_port_data_pins_out[15:0] == $past(host_port_out[15:0]))
		else $error("host data not routed");
	AST_PCI: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		captured && sel.pci_en |=>
		host_port_data_pins_out[15:0] == $past(pci_ad_out[15:0]))
		else $error("pci data not routed");
	// Pads must be quiet from reset until the selection is known.
	AST_PRE_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		!captured |=> host_port_data_pins_oe == `HPMS_ZERO32)
		else $error("pads driven before capture");
	// Once captured, the valid flag stands until the next reset.
	AST_VALID_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		sel_valid |=> sel_valid)
		else $error("valid flag dropped");
	// Receive lanes follow the upper pads while the MAC is on.
	AST_RX_DATA: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		sel.ethernet_mac_unit_en |-> mii_rx_in == host_port_data_pins_in[31:24])
		else $error("mii receive lanes wrong");
	// With the MAC off the MII side sees nothing and the data pins are whole.
	AST_MAC_OFF: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
		!sel.ethernet_mac_unit_en |-> mii_rx_in == 8'h00 && mii_tx_in == 7'h00 &&
		data_pins_in == host_port_data_pins_in)
		else $error("mii active with mac off");
	// Pin 23 keeps the base function whatever the MAC strap says.
	AST_PIN23: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
		captured |=> host_port_data_pins_oe[23] == $past(base_oe[23]))
		else $error("pin 23 taken by mii");
	COV_HOST: cover property (@(posedge clk) captured && !sel.pci_en);
	COV_BOTH: cover property (@(posedge clk)
		captured && sel.pci_en && sel.ethernet_mac_unit_en);
	COV_CAPTURE: cover property (@(posedge clk) capture_now);
	COV_PCI: cover property (@(posedge clk) captured && sel.pci_en);
	COV_MAC: cover property (@(posedge clk) captured && sel.ethernet_mac_unit_en);
endmodule : hpms_pin_select
`default_nettype wire

// ===== testbench/hpms_board_model.sv
// Board model: strap resistors and an external address controller.
`timescale 1ns/1ps
`default_nettype none
module hpms_board_model (
	input wire logic rst_n, // Device reset, active low.
	input wire logic pci_pull, // PCI strap pull-up fitted.
	input wire logic mac_pull, // MAC strap pull-up fitted.
	output logic pci_select_strap, // PCI strap level.
	output logic ethernet_mac_unit_select_strap, // MAC strap level.
	output logic [18:0] external_address_lines // Controller address drive.
);
	// Straps sit low on their pull-downs unless a pull-up is fitted.
	assign pci_select_strap = pci_pull;
	assign ethernet_mac_unit_select_strap = mac_pull;
	// Undriven in reset, so the pins keep their default levels.
	assign external_address_lines = rst_n ? 19'h1_5a5a : 19'hz;
endmodule : hpms_board_model
`default_nettype wire

// ===== testbench/hpms_pin_select_tb_top.sv
// Self-checking bench for the host-port pin selection block.
`timescale 1ns/1ps
`default_nettype none
module hpms_pin_select_tb_top;
	logic clk = 1'h0, rst_n = 1'h0, pp = 1'h0, mp = 1'h0, ps, ms, sv;
	logic [31:0] pin = 32'hc3a5_5a96, ho = 32'h1234_5678, hoe = 32'hffff_ffff;
	logic [31:0] po = 32'h9abc_def0, poe = 32'h0f0f_f0f0, out, oe, dpi, m, eo, ev;
	logic [6:0] td = 7'h33, toe = 7'h5a, tx;
	logic [7:0] rx;
	logic [18:0] addr;
	hpms_pkg::hpms_sel_type sel;
	int errors = 0, checks_done = 0;
	// Rows: PCI strap, MAC strap, expected {pci_en, ethernet_mac_unit_en, mdio_en}.
	logic [4:0] rows [4] = '{5'h00, 5'h0b, 5'h14, 5'h1f};
	always #5 clk = ~clk;
	hpms_board_model i_board (.rst_n(rst_n), .pci_pull(pp), .mac_pull(mp),
		.pci_select_strap(ps), .ethernet_mac_unit_select_strap(ms),
		.external_address_lines(addr));
	hpms_pin_select i_dut (.clk(clk), .rst_n(rst_n), .pci_select_strap(ps),
		.ethernet_mac_unit_select_strap(ms), .host_port_data_pins_in(pin),
		.host_port_data_pins_out(out), .host_port_data_pins_oe(oe),
		.host_port_out(ho), .host_port_oe(hoe), .pci_ad_out(po),
		.pci_ad_oe(poe), .mii_tx_out(td), .mii_tx_oe(toe), .mii_rx_in(rx),
		.mii_tx_in(tx), .data_pins_in(dpi), .sel(sel), .sel_valid(sv));
	// Compare one value and count it.
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// Print the counts and the verdict, then stop.
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// Reset with the given straps; a capture that never comes ends the run.
	task automatic boot(logic p, logic q);
		int k;
		@(posedge clk);
		rst_n <= 1'h0;
		pp <= p;
		mp <= q;
		repeat (10) @(posedge clk);
		chk("rst", 32'h0, {oe[30:0], sv});
		chk("addr", {13'h0, 19'hz}, {13'h0, addr});
		rst_n <= 1'h1;
		for (k = 0; k < 20 && sv !== 1'h1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 20) begin
			errors++;
			tally_and_finish();
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : boot
	// Each row boots the block, then checks selection and pin routing.
	initial begin
		for (int i = 0; i < 4; i++) begin
			boot(rows[i][4], rows[i][3]);
			m = rows[i][3] ? 32'hff7f_0000 : 32'h0000_0000;
			eo = (rows[i][4] ? poe : hoe) & ~m | {9'h0, toe & m[22:16], 16'h0};
			ev = (rows[i][4] ? po : ho) & ~m | {9'h0, td & m[22:16], 16'h0};
			chk("sel", {29'h0, rows[i][2:0]}, {29'h0, sel});
			chk("oe", eo, oe);
			chk("out", ev & eo, out & eo);
			chk("rx", {24'h0, pin[31:24] & m[31:24]}, {24'h0, rx});
			chk("tx", {25'h0, pin[22:16] & m[22:16]}, {25'h0, tx});
			chk("din", pin & ~m, dpi);
		end
		// Straps moved after capture must not alter the selection.
		@(posedge clk);
		pp <= 1'h0;
		mp <= 1'h0;
		repeat (8) @(posedge clk);
		#1;
		chk("held", 32'h7, {29'h0, sel});
		tally_and_finish();
	end
endmodule : hpms_pin_select_tb_top
`default_nettype wire
